// ---- include/sock_status_pkg.sv ----
// Constants for the socket interface status register block
package sock_status_pkg;
  // Address map, byte offsets inside the socket register space
  localparam int ADDR_W = 12;
  localparam logic [11:0] SOCK_SPACE_BASE = 12'h800;
  localparam logic [11:0] SOCKET_STRIDE = 12'h040;
  localparam logic [11:0] STATUS_OFS = 12'h001;
  localparam logic [11:0] STATUS_ADDR_A = 12'h801;
  localparam logic [11:0] STATUS_ADDR_B = 12'h841;
  // Field positions in the status byte
  localparam int BIT_RSVD = 7;
  localparam int BIT_PWR = 6;
  localparam int BIT_READY = 5;
  localparam int BIT_WP = 4;
  localparam int BIT_CD2 = 3;
  localparam int BIT_CD1 = 2;
  localparam int BIT_BVD_HI = 1;
  localparam int BIT_BVD_LO = 0;
  // Positions of the socket pins in the synchronised vector
  localparam int PIN_BVD1 = 0;
  localparam int PIN_BVD2 = 1;
  localparam int PIN_CD1N = 2;
  localparam int PIN_CD2N = 3;
  localparam int PIN_WP = 4;
  localparam int PIN_READY = 5;
  localparam int PIN_COUNT = 6;
  // Reset values, latencies in clock cycles and the socket count limit
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int SYNC_STAGES = 2;
  localparam int READ_LATENCY = 1;
  localparam int MAX_SOCKETS = 2;
endpackage : sock_status_pkg

// ---- include/sync_bus_if.sv ----
// Carrier for synchronised socket pin levels between design modules
`timescale 1ns/100ps
interface sync_bus_if #(
  parameter int WIDTH = 6
);
  logic [WIDTH-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface : sync_bus_if

// ---- hw/pin_sync.sv ----
// Two-stage synchroniser for the asynchronous socket pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw pins and synchronised result
  input wire logic [WIDTH-1:0] rawPins,
  sync_bus_if.src syncOut
);
  // Elaboration check on the width
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // First stage feeds only the second, never any logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= '0;
    end else begin
      stage1_r <= rawPins;
    end
  end

  // Second stage is the only one the register may see
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage2_r <= '0;
    end else begin
      stage2_r <= stage1_r;
    end
  end

  assign syncOut.level = stage2_r;
endmodule : pin_sync

// ---- hw/card_socket_interface_status.sv ----
// Read-only socket interface status register, one byte per socket
//
// Functional notes
// - Bit 7 always reads zero; writes to it have no effect.
// - Bit 6 shows socket power on, zero when off and after reset.
// - Bit 5 follows the card READY level.
// - Bit 4 equals the card write protect level; one means read-only.
// - Bit 3 is the inverse of the second card detect pin.
// - Bit 2 is the inverse of the first card detect pin.
// - Memory card: bits 1:0 carry BVD2 high, BVD1 low.
// - I/O card: bits 1:0 carry SPKR high, STSCHG low, undecoded.
// - After reset top two bits read zero, lower six follow the socket.
// - Register sits at offset 01h for socket A, 41h for socket B.
`timescale 1ns/100ps
module card_socket_interface_status #(
  parameter int NumSockets = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register read port
  input wire logic regRd,
  input wire logic [11:0] regAddr,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // Power state from the power control logic
  input wire logic [NumSockets-1:0] socketPowerOn,
  // Socket pins, asynchronous to clk
  input wire logic [NumSockets-1:0] cardReady,
  input wire logic [NumSockets-1:0] cardWriteProtect,
  input wire logic [NumSockets-1:0] cardDetectOne_n,
  input wire logic [NumSockets-1:0] cardDetectTwo_n,
  input wire logic [NumSockets-1:0] bvd1Stschg,
  input wire logic [NumSockets-1:0] bvd2Spkr
);
  localparam int SyncW = NumSockets * sock_status_pkg::PIN_COUNT;

  // Elaboration check on the socket count
  if (NumSockets < 1 || NumSockets > sock_status_pkg::MAX_SOCKETS) begin : g_bad_count
    $error("NumSockets must be 1 or 2");
  end

  logic [SyncW-1:0] rawPins;
  logic [NumSockets-1:0] socketPowerOn_r;
  logic [7:0] statusWord [NumSockets];
  logic [7:0] rdData_nxt;
  logic [7:0] regRdData_r;
  logic regRdValid_r;

  sync_bus_if #(.WIDTH(SyncW)) pinBus ();

  // Decode a byte address to a socket number, minus one when unmapped
  function automatic int socketOf(input logic [11:0] addr);
    int hit;
    hit = -1;
    for (int s = 0; s < NumSockets; s++) begin
      if (addr == 12'(sock_status_pkg::SOCK_SPACE_BASE + sock_status_pkg::STATUS_OFS
                      + 12'(s) * sock_status_pkg::SOCKET_STRIDE)) begin
        hit = s;
      end
    end
    return hit;
  endfunction : socketOf

  // Pack pins per socket and derive each status byte
  for (genvar s = 0; s < NumSockets; s++) begin : g_socket
    localparam int B = s * sock_status_pkg::PIN_COUNT;
    assign rawPins[B + sock_status_pkg::PIN_BVD1] = bvd1Stschg[s];
    assign rawPins[B + sock_status_pkg::PIN_BVD2] = bvd2Spkr[s];
    assign rawPins[B + sock_status_pkg::PIN_CD1N] = cardDetectOne_n[s];
    assign rawPins[B + sock_status_pkg::PIN_CD2N] = cardDetectTwo_n[s];
    assign rawPins[B + sock_status_pkg::PIN_WP] = cardWriteProtect[s];
    assign rawPins[B + sock_status_pkg::PIN_READY] = cardReady[s];

    // Reserved bit tied low, write path does not exist
    assign statusWord[s][sock_status_pkg::BIT_RSVD] = 1'b0;
    assign statusWord[s][sock_status_pkg::BIT_PWR] = socketPowerOn_r[s];
    assign statusWord[s][sock_status_pkg::BIT_READY] =
      pinBus.level[B + sock_status_pkg::PIN_READY];
    assign statusWord[s][sock_status_pkg::BIT_WP] =
      pinBus.level[B + sock_status_pkg::PIN_WP];
    // Detect pins are active low, the bits report insertion
    assign statusWord[s][sock_status_pkg::BIT_CD2] =
      ~pinBus.level[B + sock_status_pkg::PIN_CD2N];
    assign statusWord[s][sock_status_pkg::BIT_CD1] =
      ~pinBus.level[B + sock_status_pkg::PIN_CD1N];
    // Shared pins: BVD2/SPKR and BVD1/STSCHG, so no mode mux needed
    assign statusWord[s][sock_status_pkg::BIT_BVD_HI] =
      pinBus.level[B + sock_status_pkg::PIN_BVD2];
    assign statusWord[s][sock_status_pkg::BIT_BVD_LO] =
      pinBus.level[B + sock_status_pkg::PIN_BVD1];
  end

  // Pins change at card whim, so sample them through two flops
  pin_sync #(.WIDTH(SyncW)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .rawPins(rawPins),
    .syncOut(pinBus.src)
  );

  // Power state is already in this domain, one register stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      socketPowerOn_r <= '0;
    end else begin
      socketPowerOn_r <= socketPowerOn;
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    int sel;
    sel = socketOf(regAddr);
    rdData_nxt = 8'h00;
    if (sel >= 0) begin
      rdData_nxt = statusWord[sel];
    end
  end

  // Read data is held until the next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_r <= sock_status_pkg::STATUS_RESET;
    end else if (regRd) begin
      regRdData_r <= rdData_nxt;
    end
  end

  // One-cycle valid pulse per read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdValid_r <= 1'b0;
    end else begin
      regRdValid_r <= regRd;
    end
  end

  assign regRdData = regRdData_r;
  assign regRdValid = regRdValid_r;

  // Cycles since reset release, saturating, for the reset check and the pin checks
  logic [1:0] sinceReset_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sinceReset_r <= 2'h0;
    end else if (sinceReset_r != 2'h3) begin
      sinceReset_r <= sinceReset_r + 2'h1;
    end
  end

  sequence s_readA;
    regRd && regAddr == sock_status_pkg::STATUS_ADDR_A;
  endsequence

  sequence s_readB;
    regRd && regAddr == sock_status_pkg::STATUS_ADDR_B;
  endsequence

  property p_rsvd_zero;
    @(posedge clk) disable iff (!arst_n)
      regRdValid |-> !regRdData[sock_status_pkg::BIT_RSVD];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

  property p_power;
    @(posedge clk) disable iff (!arst_n)
      s_readA |=> regRdData[sock_status_pkg::BIT_PWR] == $past(socketPowerOn[0], 2);
  endproperty
  a_power: assert property (p_power) else $error("power bit wrong");

  property p_ready;
    @(posedge clk) disable iff (!arst_n)
      s_readA ##0 (sinceReset_r == 2'h3) |=>
        regRdData[sock_status_pkg::BIT_READY] == $past(cardReady[0], 3);
  endproperty
  a_ready: assert property (p_ready) else $error("ready bit wrong");

  property p_wp;
    @(posedge clk) disable iff (!arst_n)
      s_readA ##0 (sinceReset_r == 2'h3) |=>
        regRdData[sock_status_pkg::BIT_WP] == $past(cardWriteProtect[0], 3);
  endproperty
  a_wp: assert property (p_wp) else $error("write protect bit wrong");

  property p_cd2;
    @(posedge clk) disable iff (!arst_n)
      s_readA ##0 (sinceReset_r == 2'h3) |=>
        regRdData[sock_status_pkg::BIT_CD2] == !$past(cardDetectTwo_n[0], 3);
  endproperty
  a_cd2: assert property (p_cd2) else $error("detect two bit wrong");

  property p_cd1;
    @(posedge clk) disable iff (!arst_n)
      s_readA ##0 (sinceReset_r == 2'h3) |=>
        regRdData[sock_status_pkg::BIT_CD1] == !$past(cardDetectOne_n[0], 3);
  endproperty
  a_cd1: assert property (p_cd1) else $error("detect one bit wrong");

  property p_battery;
    @(posedge clk) disable iff (!arst_n)
      s_readA ##0 (sinceReset_r == 2'h3) |=>
        regRdData[1:0] == {$past(bvd2Spkr[0], 3), $past(bvd1Stschg[0], 3)};
  endproperty
  a_battery: assert property (p_battery) else $error("battery field wrong");

  property p_reset_top;
    @(posedge clk) disable iff (!arst_n)
      (sinceReset_r == 2'h0) |-> regRdData[7:6] == 2'b00 ##1 regRdData[7:6] == 2'b00;
  endproperty
  a_reset_top: assert property (p_reset_top) else $error("top bits nonzero after reset");

  property p_unmapped;
    @(posedge clk) disable iff (!arst_n)
      regRd && socketOf(regAddr) < 0 |=> regRdValid && regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  if (NumSockets > 1) begin : g_b_check
    property p_socket_b;
      @(posedge clk) disable iff (!arst_n)
        s_readB ##0 (sinceReset_r == 2'h3) |=>
          regRdValid && regRdData[sock_status_pkg::BIT_CD1] == !$past(cardDetectOne_n[1], 3);
    endproperty
    a_socket_b: assert property (p_socket_b) else $error("socket B read wrong");
  end
endmodule : card_socket_interface_status

// ---- test/card_model.sv ----
// Behavioural model of a 16-bit card sitting in one socket
`timescale 1ns/100ps
module card_model (
  // Card state chosen by the bench
  input wire logic inserted,
  input wire logic seated,
  input wire logic ioCard,
  input wire logic ready,
  input wire logic writeProtect,
  input wire logic [1:0] battery,
  input wire logic spkr,
  input wire logic stschg,
  // Socket pins
  output logic readyPin,
  output logic wpPin,
  output logic cd1Pin_n,
  output logic cd2Pin_n,
  output logic bvd1Pin,
  output logic bvd2Pin
);
  // Empty socket: host pull-ups win, so every pin floats high
  assign readyPin = inserted ? ready : 1'b1;
  assign wpPin = inserted ? writeProtect : 1'b1;
  // Partial insertion grounds only the second detect contact
  assign cd2Pin_n = !inserted;
  assign cd1Pin_n = !(inserted && seated);
  // Shared pins carry battery state or audio and status change
  assign bvd1Pin = !inserted ? 1'b1 : (ioCard ? stschg : battery[0]);
  assign bvd2Pin = !inserted ? 1'b1 : (ioCard ? spkr : battery[1]);
endmodule : card_model

// ---- test/tb_card_socket_interface_status.sv ----
// Self-checking bench for the socket interface status register
`timescale 1ns/100ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin errors++; $display("BAD %0t %h vs %h", $time, a, b); end end
module tb_card_socket_interface_status;
  // Clock, reset and read port
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic regRd = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regRdData;
  logic regRdValid;
  // Socket side: bench commands and pin wires
  logic [1:0] socketPowerOn = 2'b00;
  logic [8:0] ctl [2] = '{9'h000, 9'h000};
  // Each socket model drives one bit of these, so they are nets
  wire [1:0] pRdy, pWp, pCd1, pCd2, pB1, pB2;
  logic [7:0] expQ [$];
  logic [7:0] e;
  int errors = 0;
  int nCompared = 0;
  logic [11:0] badAddr [4] = '{12'h800, 12'h001, 12'h881, 12'h842};

  always #2.5 clk = ~clk;

  card_socket_interface_status #(.NumSockets(2)) i_dut (.clk(clk), .arst_n(arst_n),
    .regRd(regRd), .regAddr(regAddr), .regRdData(regRdData), .regRdValid(regRdValid),
    .socketPowerOn(socketPowerOn), .cardReady(pRdy), .cardWriteProtect(pWp),
    .cardDetectOne_n(pCd1), .cardDetectTwo_n(pCd2), .bvd1Stschg(pB1), .bvd2Spkr(pB2));

  // One card model per socket
  for (genvar s = 0; s < 2; s++) begin : g_card
    card_model i_card (.inserted(ctl[s][8]), .seated(ctl[s][7]), .ioCard(ctl[s][6]),
      .ready(ctl[s][5]), .writeProtect(ctl[s][4]), .battery(ctl[s][3:2]), .spkr(ctl[s][1]),
      .stschg(ctl[s][0]), .readyPin(pRdy[s]), .wpPin(pWp[s]), .cd1Pin_n(pCd1[s]),
      .cd2Pin_n(pCd2[s]), .bvd1Pin(pB1[s]), .bvd2Pin(pB2[s]));
  end

  // Status byte built from the settled pins, never from the design
  function automatic logic [7:0] expect_status(input int s);
    return {1'b0, socketPowerOn[s], pRdy[s], pWp[s], ~pCd2[s], ~pCd1[s], pB2[s], pB1[s]};
  endfunction : expect_status

  task automatic final_report;
    if (errors == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Request held one cycle per call; back-to-back calls keep regRd high
  task automatic do_read(input logic [11:0] a, input logic [7:0] x);
    @(posedge clk);
    #1;
    regRd = 1'b1;
    regAddr = a;
    expQ.push_back(x);
  endtask : do_read

  task automatic end_read;
    @(posedge clk);
    #1;
    regRd = 1'b0;
  endtask : end_read

  // Pins need two sync flops plus margin before a read may trust them
  task automatic settle;
    repeat (sock_status_pkg::SYNC_STAGES + 2) @(posedge clk);
  endtask : settle

  task automatic read_both;
    do_read(sock_status_pkg::STATUS_ADDR_A, expect_status(0));
    do_read(sock_status_pkg::STATUS_ADDR_B, expect_status(1));
  endtask : read_both

  // Result checker: valid stands one cycle, so look mid-cycle
  always @(negedge clk) begin
    if (regRdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        errors++;
        $display("BAD %0t unexpected read data", $time);
      end else begin
        e = expQ.pop_front();
        `CHK(regRdData, e)
      end
    end
  end

  // Main sequence
  initial begin
    void'($urandom(13));
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    settle();
    read_both();
    end_read();
    for (int i = 0; i < 60; i++) begin
      ctl[0] = 9'($urandom);
      ctl[1] = 9'($urandom);
      socketPowerOn = 2'($urandom);
      settle();
      read_both();
      do_read(badAddr[i % 4], 8'h00);
      do_read(sock_status_pkg::STATUS_ADDR_A, expect_status(0));
      end_read();
    end
    // Reset in mid-run clears the read port
    settle();
    @(posedge clk);
    #1 arst_n = 1'b0;
    @(posedge clk);
    #1;
    `CHK(regRdData, 8'h00)
    `CHK(regRdValid, 1'b0)
    arst_n = 1'b1;
    socketPowerOn = 2'b10;
    settle();
    read_both();
    end_read();
    for (int k = 0; k < 10 && expQ.size() > 0; k++) @(posedge clk);
    if (expQ.size() != 0) begin
      errors++;
      $display("BAD %0t reads left without answer", $time);
    end
    final_report();
  end

  // Hang guard
  initial begin
    #100000;
    errors++;
    $display("BAD %0t run timed out", $time);
    final_report();
  end
endmodule : tb_card_socket_interface_status
